// ---- core/pppwm_pkg.sv ----
// Purpose: shared constants and types for the push-pull bridge pwm output stage
// Assumes: one clock, synchronous active-low reset
// Notes:   dead-band counts are 8 bits wide
package pppwm_pkg;
  localparam int unsigned DB_W       = 8;
  localparam logic [7:0]  DB_ZERO    = 8'h00;
  localparam logic [7:0]  DB_ONE     = 8'h01;
  localparam logic        PHASE_ODD  = 1'b0;

  // per-group waveform phase
  typedef enum {PPPWM_IDLE, PPPWM_DBR, PPPWM_PRI, PPPWM_DBF, PPPWM_COMP} pppwm_state_t;

  // the six bridge drives travel together
  typedef struct packed {
    logic pri_a;
    logic pri_b;
    logic pri_c;
    logic pri_d;
    logic comp_e;
    logic comp_f;
  } pppwm_drv_t;

  // dead-band configuration
  typedef struct packed {
    logic            rise_en;
    logic            fall_en;
    logic [DB_W-1:0] rise_cnt;
    logic [DB_W-1:0] fall_cnt;
  } pppwm_db_cfg_t;
endpackage : pppwm_pkg

// ---- core/pppwm_top.sv ----
// Purpose: push-pull pwm with four primary and two complementary outputs
// Assumes: time-base events are one-cycle pulses synchronous to i_mclk
// Notes:   steering is not provided; output mapping is fixed by the mode
// Behaviour
// - six outputs alternate groups on odd/even periods
// - rising and falling dead band available
// - no steering; fixed output assignment
// - primary drive on outputs a, b, c, d
// - complementary e for odd, f for even
// - a equals c, b equals d
// - separate edge handling per odd/even period
// - odd rise: e off, delay, a/c on
// - odd fall: a/c off, delay, e on
// - even rise: f off, delay, b/d on
// - even fall: b/d off, delay, f on
// - one shared 8-bit counter with separate rising and falling compare values
// - counter advances every i_mclk edge, holding at all ones
// - fall during rise delay: restart, suppress primary
// - rise during fall delay: restart, suppress complementary
`timescale 1ns/1ps
`default_nettype none
module pppwm_top
  import pppwm_pkg::*;
(
  // clock and reset
  input  wire logic                     i_mclk,
  input  wire logic                     i_rstn,
  // mode and dead-band setup
  input  wire logic                     i_enable,
  input  wire pppwm_pkg::pppwm_db_cfg_t i_db_cfg,
  // time-base events
  input  wire logic                     i_period_evt,
  input  wire logic                     i_rise_evt,
  input  wire logic                     i_fall_evt,
  // bridge drives
  output logic                          o_primary_out_a,
  output logic                          o_primary_out_b,
  output logic                          o_primary_out_c,
  output logic                          o_primary_out_d,
  output logic                          o_comp_out_e,
  output logic                          o_comp_out_f,
  // current phase, high in even periods
  output logic                          o_even_period
);
  import pppwm_pkg::*;

  logic            enable_ff;
  logic            phase_ff;
  pppwm_state_t    state_ff [2];
  logic [DB_W-1:0] db_cnt_ff;
  pppwm_drv_t      drv_ff;
  logic            start_edge;

  ////////////////////////////////////////////////////////////////////////
  // phase tracking; first period after enable is odd
  assign start_edge = i_enable & ~enable_ff;

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      enable_ff <= 1'b0;
    else
      enable_ff <= i_enable;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn || !i_enable || start_edge)
      phase_ff <= PHASE_ODD;
    else if (i_period_evt)
      phase_ff <= ~phase_ff;
  end

  ////////////////////////////////////////////////////////////////////////
  // per-group state; only the active group follows edge events
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_grp
      logic active;
      assign active = i_enable && (phase_ff == 1'(g));

      always_ff @(posedge i_mclk)
      begin
        if (!i_rstn || !i_enable)
          state_ff[g] <= PPPWM_IDLE;
        else if (!active)
          state_ff[g] <= PPPWM_IDLE;               // other group rests
        else if (i_rise_evt)
          // a rise mid falling delay restarts rising delay
          state_ff[g] <= i_db_cfg.rise_en ? PPPWM_DBR : PPPWM_PRI;
        else if (i_fall_evt)
          state_ff[g] <= i_db_cfg.fall_en ? PPPWM_DBF : PPPWM_COMP;
        else
        begin
          case (state_ff[g])
            PPPWM_DBR:
              if (db_cnt_ff >= i_db_cfg.rise_cnt)
                state_ff[g] <= PPPWM_PRI;
            PPPWM_DBF:
              if (db_cnt_ff >= i_db_cfg.fall_cnt)
                state_ff[g] <= PPPWM_COMP;
            default:
              state_ff[g] <= state_ff[g];
          endcase
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // shared dead-band counter; one delay runs at a time, so rising and
  // falling counts share storage while keeping separate compare values
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn || i_rise_evt || i_fall_evt)
      db_cnt_ff <= DB_ONE;                         // restart on each edge
    else if (db_cnt_ff != '1)
      db_cnt_ff <= db_cnt_ff + DB_ONE;
  end

  ////////////////////////////////////////////////////////////////////////
  // output decode; fixed mapping, no steering
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      drv_ff <= '0;
    else
    begin
      drv_ff.pri_a  <= (state_ff[0] == PPPWM_PRI);
      drv_ff.pri_c  <= (state_ff[0] == PPPWM_PRI);
      drv_ff.pri_b  <= (state_ff[1] == PPPWM_PRI);
      drv_ff.pri_d  <= (state_ff[1] == PPPWM_PRI);
      drv_ff.comp_e <= (state_ff[0] == PPPWM_COMP);
      drv_ff.comp_f <= (state_ff[1] == PPPWM_COMP);
    end
  end

  assign o_primary_out_a = drv_ff.pri_a;
  assign o_primary_out_b = drv_ff.pri_b;
  assign o_primary_out_c = drv_ff.pri_c;
  assign o_primary_out_d = drv_ff.pri_d;
  assign o_comp_out_e    = drv_ff.comp_e;
  assign o_comp_out_f    = drv_ff.comp_f;
  assign o_even_period   = phase_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_odd_rise_nodb;
    i_enable && !phase_ff && i_rise_evt && !i_db_cfg.rise_en;
  endsequence

  property p_ac_equal;
    @(posedge i_mclk) disable iff (!i_rstn) o_primary_out_a == o_primary_out_c;
  endproperty
  a_ac_equal: assert property (p_ac_equal) else $error("a and c differ");

  property p_bd_equal;
    @(posedge i_mclk) disable iff (!i_rstn) o_primary_out_b == o_primary_out_d;
  endproperty
  a_bd_equal: assert property (p_bd_equal) else $error("b and d differ");

  property p_no_overlap_odd;
    @(posedge i_mclk) disable iff (!i_rstn) !(o_primary_out_a && o_comp_out_e);
  endproperty
  a_no_overlap_odd: assert property (p_no_overlap_odd) else $error("a and e overlap");

  property p_groups_alt;
    @(posedge i_mclk) disable iff (!i_rstn) !(o_primary_out_a && o_primary_out_b);
  endproperty
  a_groups_alt: assert property (p_groups_alt) else $error("both groups on");

  property p_odd_rise_nodb;
    @(posedge i_mclk) disable iff (!i_rstn)
      s_odd_rise_nodb ##1 !i_fall_evt && !i_period_evt && i_enable |=> o_primary_out_a;
  endproperty
  a_odd_rise_nodb: assert property (p_odd_rise_nodb) else $error("a late");

  property p_rise_db;
    @(posedge i_mclk) disable iff (!i_rstn)
      (i_enable && !phase_ff && i_rise_evt && i_db_cfg.rise_en && i_db_cfg.rise_cnt > 8'h02)
      |=> ##1 !o_primary_out_a && !o_comp_out_e;
  endproperty
  a_rise_db: assert property (p_rise_db) else $error("rise dead band skipped");

  property p_fall_off;
    @(posedge i_mclk) disable iff (!i_rstn)
      (i_enable && !phase_ff && i_fall_evt && !i_rise_evt) |=> ##1 !o_primary_out_a;
  endproperty
  a_fall_off: assert property (p_fall_off) else $error("a not off");

  property p_even_fall;
    @(posedge i_mclk) disable iff (!i_rstn)
      (i_enable && phase_ff && i_fall_evt && !i_rise_evt) |=> ##1 !o_primary_out_b;
  endproperty
  a_even_fall: assert property (p_even_fall) else $error("b not off");

  property p_phase_start;
    @(posedge i_mclk) disable iff (!i_rstn) $rose(i_enable) |=> !o_even_period;
  endproperty
  a_phase_start: assert property (p_phase_start) else $error("not odd first");
endmodule : pppwm_top
`default_nettype wire

// ---- testbench/pppwm_bridge.sv ----
// Purpose: bridge-side model that flags shoot-through on either leg
// Assumes: a high drive means the switch conducts
// Notes:   only watches the drives, never loads them
`timescale 1ns/1ps
`default_nettype none
module pppwm_bridge
(
  // bridge drives
  input  wire logic i_pri_a,
  input  wire logic i_pri_b,
  input  wire logic i_comp_e,
  input  wire logic i_comp_f,
  // leg conduction fault
  output logic      o_shoot
);
  // both switches of one leg on together would short the supply
  assign o_shoot = (i_pri_a & i_comp_e) | (i_pri_b & i_comp_f);
endmodule : pppwm_bridge
`default_nettype wire

// ---- testbench/push_pull_bridge_pwm_outputs_tb.sv ----
// Purpose: self-checking bench for the push-pull output stage
// Assumes: drives packed as {a,b,c,d,e,f}, events are one-cycle pulses
// Notes:   every output change pops one expected vector off the queue
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module push_pull_bridge_pwm_outputs_tb;
  import pppwm_pkg::*;
  logic          mclk = 1'b0, rstn = 1'b0, en = 1'b0, pe = 1'b0, re = 1'b0, fe = 1'b0;
  logic          a, b, c, d, e, f, even, shoot, ph, ov, ov2;
  pppwm_db_cfg_t cfg = '0;
  pppwm_drv_t    obs, last, w, pv, cv, exp_q[$];
  int            error_cnt = 0, comparisons = 0, cyc = 0, t, t_q[$];
  logic [31:0]   seed = 32'ha6bf;
  //////////////////////////////////////////////////////////////////////////////
  // clock and design
  initial forever #5 mclk = ~mclk;
  pppwm_top i_dut (.i_mclk(mclk), .i_rstn(rstn), .i_enable(en), .i_db_cfg(cfg),
    .i_period_evt(pe), .i_rise_evt(re), .i_fall_evt(fe), .o_primary_out_a(a),
    .o_primary_out_b(b), .o_primary_out_c(c), .o_primary_out_d(d),
    .o_comp_out_e(e), .o_comp_out_f(f), .o_even_period(even));
  pppwm_bridge i_bridge (.i_pri_a(a), .i_pri_b(b), .i_comp_e(e), .i_comp_f(f), .o_shoot(shoot));
  assign obs = {a, b, c, d, e, f};
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // one-cycle event, then an idle gap
  task automatic pulse(ref logic s, input int gap);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(gap);
  endtask : pulse
  // expected drive and the edge count at which it must appear
  task automatic note(input pppwm_drv_t v, input int dt);
    exp_q.push_back(v);
    t_q.push_back(cyc + dt);
  endtask : note
  task automatic report_and_stop;
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////////////////////////////////////
  // monitor: sampled after the edge so registered drives have landed
  always @(posedge mclk)
  begin
    cyc++;
    #2;
    `CHK("shoot", 1'b0, shoot)
    if (rstn && obs !== last)
    begin
      `CHK("queued", 1'b1, exp_q.size() > 0)
      w = exp_q.size() ? exp_q.pop_front() : 'x;
      t = t_q.size() ? t_q.pop_front() : -1;
      `CHK("drive", w, obs)
      `CHK("time", t, cyc)
    end
    last = obs;
  end
  // watchdog well past the expected run length
  initial
  begin
    repeat (6000) @(posedge mclk);
    error_cnt++;
    report_and_stop;
  end
  //////////////////////////////////////////////////////////////////////////////
  // stimulus: odd/even periods, dead band random for 8 periods then forced on, with overlaps
  initial
  begin
    tick(6);
    rstn = 1'b1;
    en = 1'b1;
    tick(2);
    for (int p = 0; p < 16; p++)
    begin
      seed = xs(seed);
      ph = p[0];
      pv = ph ? 6'b010100 : 6'b101000;
      cv = ph ? 6'b000001 : 6'b000010;
      cfg = '{rise_en: p[3] | seed[10], fall_en: p[3] | seed[11],
              rise_cnt: 8'h04 + seed[3:0], fall_cnt: 8'h04 + seed[7:4]};
      ov = cfg.rise_en & seed[8];
      ov2 = cfg.fall_en & seed[9];
      if (p > 0)
      begin
        note('0, 3);
        pulse(pe, 2);
      end
      `CHK("phase", ph, even)
      if (!ov) note(pv, cfg.rise_en ? cfg.rise_cnt + 2 : 2);
      pulse(re, ov ? 2 : cfg.rise_cnt + 6);
      if (cfg.fall_en && !ov) note('0, 2);
      if (!ov2) note(cv, cfg.fall_en ? cfg.fall_cnt + 2 : 2);
      pulse(fe, ov2 ? 2 : cfg.fall_cnt + 6);
      // a rise inside the falling delay keeps the comp drive off
      if (ov2)
      begin
        note(pv, cfg.rise_en ? cfg.rise_cnt + 2 : 2);
        pulse(re, cfg.rise_cnt + 6);
        note('0, 2);
        note(cv, cfg.fall_cnt + 2);
        pulse(fe, cfg.fall_cnt + 6);
      end
    end
    // disable drops every drive and returns to the odd phase
    note('0, 2);
    en = 1'b0;
    tick(4);
    `CHK("phase", 1'b0, even)
    `CHK("pending", 0, exp_q.size())
    report_and_stop;
  end
endmodule : push_pull_bridge_pwm_outputs_tb
`default_nettype wire
